// ===== ict_pkg.sv
`default_nettype none
package ict_pkg;
    // =========================================
    // widths and field layout
    localparam int WORD_W = 24;
    localparam int DWORD_W = 48;
    localparam int ADDR_W = 23;
    localparam int SECOND_ZERO_W = 8;
    localparam int CYC_W = 2;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    // program address literal: second word low bits above first word bits 15..1
    localparam int LIT_HI_W = 7;
    localparam int LIT_MID_MSB = 15;
    localparam int LIT_ALIGN_BIT = 0;

    // =========================================
    // instruction class supplied by the fetch stage's predecode
    typedef enum logic [3:0] {
        ICT_CLS_PLAIN,
        ICT_CLS_COND,
        ICT_CLS_PC_WRITE,
        ICT_CLS_BRANCH_ALWAYS,
        ICT_CLS_CALL_IND,
        ICT_CLS_GOTO_IND,
        ICT_CLS_TABLE_RD,
        ICT_CLS_TABLE_WR,
        ICT_CLS_RETURN,
        ICT_CLS_RETURN_FROM_INTERRUPT,
        ICT_CLS_SKIP,
        ICT_CLS_DOUBLE
    } ict_class_e;

    typedef struct packed {
        logic [WORD_W-1:0] word;
        ict_class_e cls;
        logic cond_true;
        logic long_path;
    } ict_fetch_s;

    typedef struct packed {
        logic [DWORD_W-1:0] instr;
        logic [ADDR_W-1:0] program_address_literal;
        logic is_double;
        logic nop;
        logic [CYC_W-1:0] cycles;
    } ict_issue_s;
endpackage : ict_pkg
`default_nettype wire

// ===== ict_cycle_count.sv
`default_nettype none
module ict_cycle_count (
    // classification in
    input wire ict_pkg::ict_class_e cls_i,
    input wire logic cond_true_i,
    input wire logic long_path_i,
    input wire logic skip_target_double_i,
    // cycle count out
    output logic [ict_pkg::CYC_W-1:0] cycles_o
);
    import ict_pkg::*;

    // =========================================
    // cycle count per class
    always_comb begin
        cycles_o = CYC_ONE; // [RQ5]
        unique case (cls_i)
            ICT_CLS_PLAIN: cycles_o = CYC_ONE;
            ICT_CLS_DOUBLE: cycles_o = CYC_TWO; // [RQ4]
            ICT_CLS_COND: cycles_o = cond_true_i ? CYC_TWO : CYC_ONE; // [RQ6]
            ICT_CLS_PC_WRITE: cycles_o = CYC_TWO; // [RQ6]
            ICT_CLS_BRANCH_ALWAYS, ICT_CLS_CALL_IND, ICT_CLS_GOTO_IND,
            ICT_CLS_TABLE_RD, ICT_CLS_TABLE_WR, ICT_CLS_RETURN,
            ICT_CLS_RETURN_FROM_INTERRUPT:
                cycles_o = long_path_i ? CYC_THREE : CYC_TWO; // [RQ8]
            ICT_CLS_SKIP: begin
                if (!cond_true_i) begin
                    cycles_o = CYC_ONE;
                end else begin
                    cycles_o = skip_target_double_i ? CYC_THREE : CYC_TWO; // [RQ9]
                end
            end
            default: cycles_o = CYC_ONE;
        endcase
    end
endmodule : ict_cycle_count
`default_nettype wire

// ===== ict_timing.sv
// Notes on behaviour
// RQ1: a double-word instruction is one 48-bit unit from two program words.
// RQ2: the second word of a double-word instruction has its top eight bits zero.
// RQ3: a second word executed on its own behaves as a no-operation.
// RQ4: every double-word instruction takes exactly two cycles.
// RQ5: a single-word instruction takes one cycle by default.
// RQ6: true condition or program-counter change makes a single-word instruction two cycles.
// RQ7: the extra cycles are no-operations that change no state.
// RQ8: branches, indirect call/jump, table access, returns take two or three cycles.
// RQ9: taken skip takes two cycles over one word, three over two words.
// RQ10: the 23-bit program address literal has its least significant bit zero.
// RQ11: skipped words are still fetched but nullified, causing no updates.
`default_nettype none
module ict_timing #(
    // sizes the logic is built for
    parameter int INSTR_W = ict_pkg::WORD_W,
    parameter int LIT_W = ict_pkg::ADDR_W
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // fetch side
    input wire logic fetch_valid_i,
    input wire ict_pkg::ict_fetch_s fetch_i,
    input wire logic next_is_double_i,
    output logic fetch_ready_o,
    // execute side
    output logic issue_valid_o,
    output ict_pkg::ict_issue_s issue_o,
    output logic align_err_o
);
    import ict_pkg::*;

    // =========================================
    // elaboration checks
    if (INSTR_W != WORD_W) begin : g_bad_word_w
        $error("instruction word width must match the issue record");
    end
    if (LIT_W != ADDR_W) begin : g_bad_lit_w
        $error("program address literal width must match the issue record");
    end
    if (DWORD_W != WORD_W + WORD_W) begin : g_bad_dword_w
        $error("a double-word instruction must span exactly two words");
    end
    if (LIT_HI_W + LIT_MID_MSB - LIT_ALIGN_BIT + 1 != ADDR_W) begin : g_bad_lit_pack
        $error("literal fields do not add up to the literal width");
    end
    if (SECOND_ZERO_W > WORD_W) begin : g_bad_zero_w
        $error("zero field is wider than a word");
    end

    // =========================================
    // helpers
    function automatic logic second_word_ok(input logic [WORD_W-1:0] w);
        return w[WORD_W-1 -: SECOND_ZERO_W] == '0;
    endfunction : second_word_ok

    // one program word placed in the low half of the issue record
    function automatic logic [DWORD_W-1:0] widen_word(input logic [WORD_W-1:0] w);
        return {{WORD_W{1'b0}}, w};
    endfunction : widen_word

    // literal: second word low bits, then first word bits above the align bit
    function automatic logic [ADDR_W-1:0] pack_literal(input logic [WORD_W-1:0] first_w,
        input logic [WORD_W-1:0] second_w);
        return {second_w[LIT_HI_W-1:0], first_w[LIT_MID_MSB:LIT_ALIGN_BIT+1], 1'b0};
    endfunction : pack_literal

    // single-word instruction that holds fetch for its extra no-operation cycles
    function automatic logic holds_fetch(input ict_class_e cls, input logic skip_taken,
        input logic [CYC_W-1:0] cyc);
        return cls != ICT_CLS_DOUBLE && !skip_taken && cyc != CYC_ONE;
    endfunction : holds_fetch

    typedef enum {
        ST_FIRST,
        ST_SECOND,
        ST_STALL,
        ST_SKIP1,
        ST_SKIP2
    } ict_state_e;

    ict_state_e state_reg;
    logic [WORD_W-1:0] first_word_reg;
    logic [CYC_W-1:0] stall_left_reg;
    logic skip_double_reg;
    logic [CYC_W-1:0] cyc_now;

    ict_cycle_count u_count (
        .cls_i(fetch_i.cls),
        .cond_true_i(fetch_i.cond_true),
        .long_path_i(fetch_i.long_path),
        .skip_target_double_i(next_is_double_i),
        .cycles_o(cyc_now)
    );

    wire logic take = fetch_valid_i && fetch_ready_o;
    wire logic is_skip = fetch_i.cls == ICT_CLS_SKIP && fetch_i.cond_true;
    wire logic starts_double = fetch_i.cls == ICT_CLS_DOUBLE;
    // taking a single-word instruction whose extra cycles are stalls
    wire logic stall_start = take && state_reg == ST_FIRST
        && holds_fetch(fetch_i.cls, is_skip, cyc_now);

    // =========================================
    // sequencing
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_reg <= ST_FIRST;
            first_word_reg <= '0;
            stall_left_reg <= '0;
            skip_double_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_FIRST: begin
                    if (take) begin
                        if (starts_double) begin
                            first_word_reg <= fetch_i.word; // [RQ1]
                            state_reg <= ST_SECOND;
                        end else if (is_skip) begin
                            skip_double_reg <= next_is_double_i;
                            state_reg <= ST_SKIP1; // [RQ11]
                        end else if (stall_start) begin
                            stall_left_reg <= cyc_now - CYC_ONE;
                            state_reg <= ST_STALL; // [RQ6] [RQ8]
                        end
                    end
                end
                ST_SECOND: begin
                    if (take) begin
                        state_reg <= ST_FIRST; // [RQ4]
                    end
                end
                ST_STALL: begin
                    stall_left_reg <= stall_left_reg - CYC_ONE;
                    if (stall_left_reg == CYC_ONE) begin
                        state_reg <= ST_FIRST;
                    end
                end
                ST_SKIP1: begin
                    if (take) begin
                        state_reg <= skip_double_reg ? ST_SKIP2 : ST_FIRST; // [RQ9]
                    end
                end
                ST_SKIP2: begin
                    if (take) begin
                        state_reg <= ST_FIRST;
                    end
                end
            endcase
        end
    end

    // =========================================
    // fetch acceptance
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            fetch_ready_o <= 1'b0;
        end else if (state_reg == ST_STALL) begin
            // reopen fetch only for the last no-operation slot
            fetch_ready_o <= stall_left_reg == CYC_ONE; // [RQ7]
        end else if (stall_start) begin
            fetch_ready_o <= 1'b0; // [RQ6] [RQ8]
        end else begin
            fetch_ready_o <= 1'b1;
        end
    end

    // =========================================
    // issue strobe
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            issue_valid_o <= 1'b0;
        end else if (state_reg == ST_STALL) begin
            issue_valid_o <= 1'b1; // [RQ7]
        end else if (take) begin
            // the first word of a double waits for its partner
            issue_valid_o <= !(state_reg == ST_FIRST && starts_double); // [RQ1]
        end else begin
            issue_valid_o <= 1'b0;
        end
    end

    // =========================================
    // issue record
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            issue_o <= '0;
        end else if (state_reg == ST_STALL) begin
            issue_o <= '0;
            issue_o.nop <= 1'b1; // [RQ7]
        end else if (take) begin
            issue_o <= '0;
            unique case (state_reg)
                ST_FIRST: begin
                    issue_o.instr <= widen_word(fetch_i.word);
                    issue_o.cycles <= cyc_now; // [RQ5] [RQ6] [RQ8] [RQ9]
                    // a lone second word decodes as no-operation
                    issue_o.nop <= second_word_ok(fetch_i.word); // [RQ3]
                end
                ST_SECOND: begin
                    issue_o.instr <= {first_word_reg, fetch_i.word}; // [RQ1]
                    issue_o.is_double <= 1'b1;
                    issue_o.cycles <= CYC_TWO; // [RQ4]
                    issue_o.program_address_literal <=
                        pack_literal(first_word_reg, fetch_i.word); // [RQ10]
                    issue_o.nop <= !second_word_ok(fetch_i.word); // [RQ2]
                end
                ST_STALL, ST_SKIP1, ST_SKIP2: begin
                    // skipped words are fetched but change nothing
                    issue_o.instr <= widen_word(fetch_i.word);
                    issue_o.nop <= 1'b1; // [RQ11] [RQ7]
                end
            endcase
        end
    end

    // =========================================
    // zero-field and alignment errors
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            align_err_o <= 1'b0;
        end else begin
            align_err_o <= take && state_reg == ST_SECOND // [RQ2] [RQ10]
                && (!second_word_ok(fetch_i.word) || first_word_reg[LIT_ALIGN_BIT]);
        end
    end
endmodule : ict_timing
`default_nettype wire

// ===== ict_timing_asserts.sv
`default_nettype none
module ict_timing_asserts
    import ict_pkg::*;
(
    // watched ports
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic fetch_valid_i,
    input wire ict_pkg::ict_fetch_s fetch_i,
    input wire logic next_is_double_i,
    input wire logic fetch_ready_o,
    input wire logic issue_valid_o,
    input wire ict_pkg::ict_issue_s issue_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    wire logic tk;
    assign tk = fetch_valid_i && fetch_ready_o;
    // ====
    // issue timing
    plain_one_a: assert property (tk && fetch_i.cls == ICT_CLS_PLAIN |=> issue_valid_o
        && (issue_o.is_double || issue_o.nop || issue_o.cycles == CYC_ONE))
        else $error("plain count wrong");
    cond_two_a: assert property (tk && (fetch_i.cls == ICT_CLS_PC_WRITE
        || fetch_i.cls == ICT_CLS_COND && fetch_i.cond_true) |=> issue_valid_o
        && issue_o.cycles == CYC_TWO ##1 issue_valid_o && issue_o.nop)
        else $error("cond count wrong");
    multi_cyc_a: assert property (tk && fetch_i.cls inside
        {[ICT_CLS_BRANCH_ALWAYS:ICT_CLS_RETURN_FROM_INTERRUPT]} |=> issue_valid_o
        && issue_o.cycles == ($past(fetch_i.long_path) ? CYC_THREE : CYC_TWO))
        else $error("multi count wrong");
    skip_cyc_a: assert property (tk && fetch_i.cls == ICT_CLS_SKIP
        && fetch_i.cond_true |=> issue_valid_o && issue_o.cycles ==
        ($past(next_is_double_i) ? CYC_THREE : CYC_TWO) ##1 issue_valid_o && issue_o.nop)
        else $error("skip count wrong");
    dbl_two_a: assert property (issue_valid_o && issue_o.is_double
        |-> issue_o.cycles == CYC_TWO) else $error("double count wrong");
    dbl_lit_a: assert property (issue_valid_o && issue_o.is_double
        |-> issue_o.program_address_literal == {issue_o.instr[6:0], issue_o.instr[39:25], 1'b0})
        else $error("literal wrong");
    stall_hold_a: assert property (issue_valid_o && !issue_o.nop
        && !issue_o.is_double && issue_o.cycles != CYC_ONE
        && $past(fetch_i.cls) != ICT_CLS_SKIP |-> !fetch_ready_o) else $error("no stall");
    rst_quiet_a: assert property (disable iff (1'b0) srst_i
        |=> !issue_valid_o && !fetch_ready_o) else $error("reset not quiet");
endmodule : ict_timing_asserts
bind ict_timing ict_timing_asserts chk_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .fetch_valid_i(fetch_valid_i), .fetch_i(fetch_i), .next_is_double_i(next_is_double_i),
    .fetch_ready_o(fetch_ready_o), .issue_valid_o(issue_valid_o), .issue_o(issue_o));
`default_nettype wire

// ===== ict_fetch_model.sv
`default_nettype none
module ict_fetch_model
    import ict_pkg::*;
(
    // fetch handshake
    input wire logic clk_sys_i,
    input wire logic ready_i,
    output logic valid_o,
    output ict_pkg::ict_fetch_s fetch_o,
    output logic next_dbl_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        valid_o = 1'b0;
        fetch_o = '0;
        next_dbl_o = 1'b0;
    end
    // word held until the edge that takes it
    task automatic put(input logic [23:0] w, input ict_class_e c, input logic t, l, d);
        int k;
        @(negedge clk_sys_i);
        valid_o <= 1'b1;
        fetch_o <= '{w, c, t, l};
        next_dbl_o <= d;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (ready_i !== 1'b1 && k < 50);
        if (ready_i !== 1'b1) ict_timing_tb.hang();
    endtask : put
    // released word and next-double lines show the inverse, not the old value
    task automatic idle();
        @(negedge clk_sys_i);
        valid_o <= 1'b0;
        fetch_o.word <= ~fetch_o.word;
        next_dbl_o <= ~next_dbl_o;
    endtask : idle
endmodule : ict_fetch_model
`default_nettype wire

// ===== ict_timing_tb.sv
`default_nettype none
module ict_timing_tb
    import ict_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic fv, rdy, nd, iv, aerr, err_seen;
    ict_fetch_s f;
    ict_issue_s iss;
    ict_issue_s q[$];
    int fail_count = 0;
    int n_tests = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (iv === 1'b1) q.push_back(iss);
        if (aerr === 1'b1) err_seen = 1'b1;
    end
    ict_fetch_model m (.clk_sys_i(clk_sys_i), .ready_i(rdy), .valid_o(fv), .fetch_o(f),
        .next_dbl_o(nd));
    ict_timing dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .fetch_valid_i(fv), .fetch_i(f),
        .next_is_double_i(nd), .fetch_ready_o(rdy), .issue_valid_o(iv), .issue_o(iss),
        .align_err_o(aerr));
    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic slots(input string n, input int c, input logic [1:0] y, input logic z);
        m.idle();
        repeat (6) @(negedge clk_sys_i);
        chk(n, 48'(c), 48'(q.size()));
        if (q.size() > 0) chk(n, 48'({y, z}), 48'({q[0].cycles, q[0].nop}));
        for (int i = 1; i < q.size(); i++) chk(n, 48'(1), 48'(q[i].nop));
        q.delete();
    endtask : slots
    task automatic t_single();
        m.put(24'h12_3456, ICT_CLS_PLAIN, 1'b0, 1'b0, 1'b0);
        slots("plain", 1, CYC_ONE, 1'b0);
        m.put(24'h12_3456, ICT_CLS_COND, 1'b0, 1'b0, 1'b0);
        slots("cond false", 1, CYC_ONE, 1'b0);
        m.put(24'h12_3456, ICT_CLS_COND, 1'b1, 1'b0, 1'b0);
        slots("cond true", 2, CYC_TWO, 1'b0);
        m.put(24'h12_3456, ICT_CLS_PC_WRITE, 1'b0, 1'b0, 1'b0);
        slots("pc write", 2, CYC_TWO, 1'b0);
        m.put(24'h00_00ab, ICT_CLS_PLAIN, 1'b0, 1'b0, 1'b0);
        slots("lone second", 1, CYC_ONE, 1'b1);
    endtask : t_single
    task automatic t_multi();
        for (int c = 3; c <= 9; c++) begin
            for (int l = 0; l < 2; l++) begin
                m.put(24'h12_3456, ict_class_e'(c), 1'b0, l[0], 1'b0);
                slots("multi", 2 + l, l[0] ? CYC_THREE : CYC_TWO, 1'b0);
            end
        end
    endtask : t_multi
    task automatic t_skip();
        m.put(24'h12_3456, ICT_CLS_SKIP, 1'b0, 1'b0, 1'b1);
        slots("skip not taken", 1, CYC_ONE, 1'b0);
        for (int d = 0; d < 2; d++) begin
            m.put(24'h12_3456, ICT_CLS_SKIP, 1'b1, 1'b0, d[0]);
            if (d == 1) m.put(24'h00_1234, ICT_CLS_DOUBLE, 1'b0, 1'b0, 1'b0);
            m.put(24'h00_0056, ICT_CLS_PLAIN, 1'b0, 1'b0, 1'b0);
            slots("skip", 2 + d, d[0] ? CYC_THREE : CYC_TWO, 1'b0);
        end
    endtask : t_skip
    task automatic t_dbl(input logic [23:0] a, input logic [23:0] b, input logic e);
        err_seen = 1'b0;
        m.put(a, ICT_CLS_DOUBLE, 1'b0, 1'b0, 1'b0);
        m.put(b, ICT_CLS_PLAIN, 1'b0, 1'b0, 1'b0);
        m.idle();
        repeat (6) @(negedge clk_sys_i);
        chk("align err", 48'(e), 48'(err_seen));
        if (!e) begin
            chk("dbl slots", 48'(1), 48'(q.size()));
            chk("dbl instr", {a, b}, q[0].instr);
            chk("dbl lit", 48'({b[6:0], a[15:1], 1'b0}),
                48'(q[0].program_address_literal));
            chk("dbl cyc", 48'({1'b1, CYC_TWO}), 48'({q[0].is_double, q[0].cycles}));
        end
        q.delete();
    endtask : t_dbl
    task automatic results();
        if (fail_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    task automatic hang();
        fail_count++;
        results();
    endtask : hang
    initial begin
        repeat (3) @(negedge clk_sys_i);
        chk("reset out", 48'(0), 48'({rdy, iv}));
        srst_i = 1'b0;
        t_single();
        t_multi();
        t_skip();
        t_dbl(24'h00_1234, 24'h00_0056, 1'b0);
        t_dbl(24'h00_1235, 24'h00_0056, 1'b1);
        t_dbl(24'h00_1234, 24'h01_0056, 1'b1);
        results();
    end
endmodule : ict_timing_tb
`default_nettype wire
